// >>> cpmc_ctrl.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cpmc_ctrl
    import cpmc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       internal_low_rc_clk_pin,
    input  wire logic       osc_is_rc_pin,
    input  wire logic [7:0] p0_pins,
    input  wire logic [7:0] p1_pins,
    input  wire logic       irq_pending,
    input  wire logic [7:0] port2_output_latch,
    input  wire logic       fetch_req,
    input  wire logic       xram_rd_req,
    input  wire logic       xram_wr_req,
    output logic            mem_ready,
    output logic      [7:0] xram_high_addr,
    output logic            cpu_clk_en,
    output logic            cpu_run,
    output logic            periph_clk_en,
    output logic            hosc_run,
    output logic            internal_low_rc_run,
    output logic            lxtal_drive,
    output logic            idle_mode,
    output logic            stop_mode,
    output logic            serial_double_rate
);

    typedef struct packed {
        cpmc_state_t st;
        logic [11:0] warm_cnt;
        logic [2:0]  low_cnt;
        logic [2:0]  internal_low_rc_sy;
        logic [1:0]  rc_sy;
        logic [7:0]  p0_s1;
        logic [7:0]  p0_s2;
        logic [7:0]  p0_s3;
        logic [7:0]  p1_s1;
        logic [7:0]  p1_s2;
        logic [7:0]  p1_s3;
        logic        baud_dbl;
        logic        keep_low;
        logic        high_sel;
        logic        gen_flag;
        logic        stop_bit;
        logic        idle_bit;
        logic        low_clock_source_sel;
        logic [2:0]  div_sel;
        logic [2:0]  div_act;
        logic [2:0]  pwait;
        logic [2:0]  rwait;
        logic        wext;
        logic [7:0]  p1_wen;
        logic [7:0]  rdata;
        logic [7:0]  xhi;
        logic        busy;
        logic [2:0]  wcnt;
        logic        ready;
        logic        cpu_run;
        logic        periph_en;
        logic        hosc_run;
        logic        internal_low_rc_run;
        logic        lxtal_drive;
    } cpmc_regs_t;

    localparam cpmc_regs_t RST_VAL = '{
        st:       ST_WARM_HI,
        warm_cnt: WARM_HI_XTAL - 12'h001,
        high_sel: RST_HSEL,
        keep_low: RST_KEEP,
        low_clock_source_sel:     RST_LOW_CLOCK_SOURCE_SEL,
        div_sel:  RST_DIV,
        div_act:  RST_DIV,
        pwait:    RST_PWAIT,
        rwait:    RST_RWAIT,
        wext:     RST_WEXT,
        p1_wen:   RST_P1W,
        hosc_run: 1'h1,
        default:  '0
    };

    cpmc_regs_t r;
    cpmc_regs_t n;
    logic       internal_low_rc_edge;
    logic       p0_chg;
    logic       p1_chg;
    logic       pin_wake;
    logic       low_on;

    // change detect looks only at the second and third stages
    assign internal_low_rc_edge = r.internal_low_rc_sy[1] & ~r.internal_low_rc_sy[2];
    assign p0_chg    = |(r.p0_s2 ^ r.p0_s3);
    assign p1_chg    = |((r.p1_s2 ^ r.p1_s3) & r.p1_wen);
    assign pin_wake  = p0_chg | p1_chg;

    always_comb begin
        n = r;
        low_on = 1'b0;
        n.internal_low_rc_sy = {r.internal_low_rc_sy[1], r.internal_low_rc_sy[0], internal_low_rc_clk_pin};
        n.rc_sy   = {r.rc_sy[0], osc_is_rc_pin};
        n.p0_s1   = p0_pins;
        n.p0_s2   = r.p0_s1;
        n.p0_s3   = r.p0_s2;
        n.p1_s1   = p1_pins;
        n.p1_s2   = r.p1_s1;
        n.p1_s3   = r.p1_s2;
        n.ready   = 1'b0;
        n.rdata   = RD_NONE;

        // operating mode sequence
        case (r.st)
            ST_WARM_HI: begin
                if (r.warm_cnt == 12'h000) begin
                    n.st = ST_WARM_LO;
                    n.low_cnt = WARM_LO;
                end else begin
                    n.warm_cnt = r.warm_cnt - 12'h001;
                end
            end
            ST_WARM_LO: begin
                if (internal_low_rc_edge) begin
                    if (r.low_cnt == 3'h1) begin
                        n.st = ST_RUN;
                    end else begin
                        n.low_cnt = r.low_cnt - 3'h1;
                    end
                end
            end
            ST_RUN: begin
                if (r.stop_bit) begin
                    n.st = ST_STOP;
                end else if (r.idle_bit) begin
                    n.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (pin_wake | irq_pending) begin
                    n.st = ST_RUN;
                    n.idle_bit = 1'b0;
                end
            end
            ST_STOP: begin
                if (pin_wake) begin
                    n.st = ST_WARM_HI;
                    n.stop_bit = 1'b0;
                    // RC source restarts fast, crystal needs full warm-up
                    if (r.rc_sy[1]) begin
                        n.warm_cnt = WARM_HI_RC - 12'h001;
                    end else begin
                        n.warm_cnt = WARM_HI_XTAL - 12'h001;
                    end
                end
            end
            default: begin
                n.st = ST_WARM_HI;
                n.warm_cnt = WARM_HI_XTAL - 12'h001;
            end
        endcase

        // software writes come after wake clears, so a write wins
        if (reg_wr) begin
            case (reg_addr)
                ADDR_PWR: begin
                    n.baud_dbl = reg_wdata[PWR_BAUD];
                    n.keep_low = reg_wdata[PWR_KEEP];
                    n.high_sel = reg_wdata[PWR_HSEL];
                    n.gen_flag = reg_wdata[PWR_GF];
                    n.stop_bit = reg_wdata[PWR_STOP];
                    n.idle_bit = reg_wdata[PWR_IDLE];
                end
                ADDR_WAIT: begin
                    n.pwait = reg_wdata[WAIT_PW_LSB +: 3];
                    n.wext  = reg_wdata[WAIT_WE];
                    n.rwait = reg_wdata[WAIT_RW_LSB +: 3];
                end
                ADDR_P1W: begin
                    n.p1_wen = reg_wdata;
                end
                ADDR_CSEL: begin
                    n.low_clock_source_sel    = reg_wdata[CSEL_LOW_CLOCK_SOURCE_SEL];
                    n.div_sel = reg_wdata[CSEL_DIV_LSB +: 3];
                end
                ADDR_CCMD: begin
                    // any other value is dropped without effect
                    if (reg_wdata == CMD_KEY) begin
                        n.div_act = r.div_sel;
                    end
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                ADDR_PWR: begin
                    n.rdata = {r.baud_dbl, 2'h0, r.keep_low, r.high_sel,
                               r.gen_flag, r.stop_bit, r.idle_bit};
                end
                ADDR_WAIT: begin
                    n.rdata = {1'h0, r.pwait, r.wext, r.rwait};
                end
                ADDR_P1W: begin
                    n.rdata = r.p1_wen;
                end
                ADDR_CSEL: begin
                    n.rdata = {r.low_clock_source_sel, 4'h0, r.div_sel};
                end
                default: begin
                    n.rdata = RD_NONE;
                end
            endcase
        end

        // one access at a time; requests during a stretch are ignored
        if (r.busy) begin
            if (r.wcnt == 3'h0) begin
                n.busy  = 1'b0;
                n.ready = 1'b1;
            end else begin
                n.wcnt = r.wcnt - 3'h1;
            end
        end else if (fetch_req) begin
            n.busy = 1'b1;
            n.wcnt = r.pwait;
        end else if (xram_rd_req) begin
            n.busy = 1'b1;
            n.wcnt = r.rwait;
        end else if (xram_wr_req) begin
            n.busy = 1'b1;
            n.wcnt = r.wext ? XWR_EXT : 3'h0;
        end

        n.xhi = r.high_sel ? 8'h00 : port2_output_latch;

        // keep-low is taken from the stored bit, written beforehand
        low_on = (n.st != ST_STOP) | r.keep_low;
        n.cpu_run     = (n.st == ST_RUN);
        n.periph_en   = (n.st == ST_RUN) | (n.st == ST_IDLE);
        n.hosc_run    = (n.st != ST_STOP);
        n.internal_low_rc_run    = low_on & n.low_clock_source_sel;
        n.lxtal_drive = low_on & ~n.low_clock_source_sel;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r <= RST_VAL;
        end else begin
            r <= n;
        end
    end

    // divider runs only while the CPU clock is allowed
    cpmc_cpu_div u_div (
        .clock    (clock),
        .rst      (rst),
        .run      (r.cpu_run),
        .div_code (r.div_act),
        .tick     (cpu_clk_en)
    );

    assign reg_rdata          = r.rdata;
    assign mem_ready          = r.ready;
    assign xram_high_addr     = r.xhi;
    assign cpu_run            = r.cpu_run;
    assign periph_clk_en      = r.periph_en;
    assign hosc_run           = r.hosc_run;
    assign internal_low_rc_run           = r.internal_low_rc_run;
    assign lxtal_drive        = r.lxtal_drive;
    assign idle_mode          = r.st[3];
    assign stop_mode          = r.st[4];
    assign serial_double_rate = r.baud_dbl;

endmodule
`default_nettype wire

// >>> cpmc_pkg.sv
// Contract
// - reset waits 2048 high plus 5 low cycles
// - stop wake waits 2048/64 high plus 5 low
// - program reads add 0-7 cycles, reset 111
// - write-extend bit stretches external RAM writes
// - external RAM reads add 0-7 cycles, reset 001
// - divider applies only on key 0x69 command
// - codes 000..111 divide by 128 down to 1
// - low clock from crystal at 0, RC at 1
// - keep-low bit keeps low clock in stop
// - high address byte from port 2 or 0x00
// - power bit 1 enters stop mode
// - power bit 0 enters idle mode
// - port 1 wake enable per pin
// - idle gates CPU only, wake clears idle
// - stop halts all but a kept low clock, pin wake clears stop
package cpmc_pkg;

    localparam logic [7:0]  ADDR_PWR     = 8'h87;
    localparam logic [7:0]  ADDR_WAIT    = 8'h8E;
    localparam logic [7:0]  ADDR_P1W     = 8'h91;
    localparam logic [7:0]  ADDR_CSEL    = 8'hE5;
    localparam logic [7:0]  ADDR_CCMD    = 8'hE6;
    localparam logic [7:0]  CMD_KEY      = 8'h69;
    localparam logic [7:0]  RD_NONE      = 8'h00;

    localparam int          PWR_BAUD     = 7;
    localparam int          PWR_KEEP     = 4;
    localparam int          PWR_HSEL     = 3;
    localparam int          PWR_GF       = 2;
    localparam int          PWR_STOP     = 1;
    localparam int          PWR_IDLE     = 0;
    localparam int          WAIT_PW_LSB  = 4;
    localparam int          WAIT_WE      = 3;
    localparam int          WAIT_RW_LSB  = 0;
    localparam int          CSEL_LOW_CLOCK_SOURCE_SEL    = 7;
    localparam int          CSEL_DIV_LSB = 0;

    localparam logic [2:0]  RST_PWAIT    = 3'h7;
    localparam logic [2:0]  RST_RWAIT    = 3'h1;
    localparam logic        RST_WEXT     = 1'h0;
    localparam logic [2:0]  RST_DIV      = 3'h7;
    localparam logic        RST_LOW_CLOCK_SOURCE_SEL     = 1'h1;
    localparam logic        RST_HSEL     = 1'h1;
    localparam logic        RST_KEEP     = 1'h0;
    localparam logic [7:0]  RST_P1W      = 8'h00;

    localparam logic [11:0] WARM_HI_XTAL = 12'h800;
    localparam logic [11:0] WARM_HI_RC   = 12'h040;
    localparam logic [2:0]  WARM_LO      = 3'h5;
    localparam logic [2:0]  XWR_EXT      = 3'h1;
    localparam logic [6:0]  DIV_MAX      = 7'h7F;

    typedef enum logic [4:0] {
        ST_WARM_HI = 5'h01,
        ST_WARM_LO = 5'h02,
        ST_RUN     = 5'h04,
        ST_IDLE    = 5'h08,
        ST_STOP    = 5'h10
    } cpmc_state_t;

endpackage

// >>> cpmc_cpu_div.sv
`timescale 1ns/10ps
`default_nettype none
module cpmc_cpu_div
    import cpmc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [2:0] div_code,
    output logic            tick
);

    typedef struct packed {
        logic [6:0] cnt;
        logic       tick;
    } cpmc_div_t;

    cpmc_div_t  r;
    cpmc_div_t  n;
    logic [6:0] last;

    // code 000 -> 128 cycles per tick, code 111 -> every cycle
    assign last = DIV_MAX >> div_code;

    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = 7'h00;
        end else if (r.cnt >= last) begin
            // >= so a shorter divider never overruns a stale count
            n.cnt = 7'h00;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + 7'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;

endmodule
`default_nettype wire

// >>> cpmc_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module cpmc_ctrl_chk (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       mem_ready,
    input wire logic [7:0] port2_output_latch,
    input wire logic [7:0] xram_high_addr,
    input wire logic       cpu_clk_en,
    input wire logic       cpu_run,
    input wire logic       periph_clk_en,
    input wire logic       hosc_run,
    input wire logic       internal_low_rc_run,
    input wire logic       lxtal_drive,
    input wire logic       idle_mode,
    input wire logic       stop_mode
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    a_ready_pulse: assert property (mem_ready |=> !mem_ready)
        else $error("ready held longer than one cycle");
    a_stop_gates: assert property (stop_mode |->
        !hosc_run && !cpu_run && !periph_clk_en)
        else $error("clocks alive in stop");
    a_idle_gates: assert property (idle_mode |->
        !cpu_run && periph_clk_en && hosc_run)
        else $error("idle gating wrong");
    a_run_alone: assert property (cpu_run |-> !idle_mode && !stop_mode)
        else $error("cpu runs in a low power mode");
    a_wake_warm: assert property ($fell(stop_mode) |-> !cpu_run [*8])
        else $error("cpu runs without warm-up after stop");
    a_high_byte: assert property (xram_high_addr == 8'h00 ||
        xram_high_addr == $past(port2_output_latch))
        else $error("high address byte from wrong source");
    // one cycle grace after reset and stop, where both outputs may settle
    a_low_one: assert property (!$past(rst) && !stop_mode &&
        !$past(stop_mode) |-> internal_low_rc_run ^ lxtal_drive)
        else $error("low clock source not exclusive");
    a_clk_gated: assert property (!cpu_run && !$past(cpu_run) &&
        !$past(cpu_run, 2) |-> !cpu_clk_en)
        else $error("cpu tick while halted");
endmodule

bind cpmc_ctrl cpmc_ctrl_chk i_chk (.clock, .rst, .mem_ready,
    .port2_output_latch, .xram_high_addr, .cpu_clk_en, .cpu_run,
    .periph_clk_en, .hosc_run, .internal_low_rc_run, .lxtal_drive, .idle_mode,
    .stop_mode);
`default_nettype wire

// >>> cpmc_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// cpu side: one access per go pulse, lat = cycles from request to ready
module cpmc_cpu_model (
    input  wire logic       clock,
    input  wire logic [1:0] kind,
    input  wire logic       go,
    input  wire logic       mem_ready,
    output logic            fetch_req = 1'h0,
    output logic            xram_rd_req = 1'h0,
    output logic            xram_wr_req = 1'h0,
    output logic            internal_low_rc_clk_pin = 1'h0,
    output int              lat = 0
);
    int n = 0;
    int cnt = 0;

    // low rc runs free; a short period keeps the warm-up runs brief
    always @(posedge clock) begin
        n <= n + 1;
        internal_low_rc_clk_pin <= n[2];
    end

    always @(posedge clock) begin
        fetch_req   <= go && kind == 2'h0;
        xram_rd_req <= go && kind == 2'h1;
        xram_wr_req <= go && kind == 2'h2;
        cnt <= go ? 0 : cnt + 1;
        // cleared on each request so a lost answer cannot pass as stale
        if (mem_ready)
            lat <= cnt;
        else if (go)
            lat <= 0;
    end
endmodule
`default_nettype wire

// >>> test_clock_power_mgmt_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_clock_power_mgmt_ctrl
    import cpmc_pkg::*;
;
    logic       clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0;
    logic       irq_pending = 0, osc_is_rc_pin = 1;
    logic [7:0] reg_addr = 0, reg_wdata = 0, p0_pins = 0, p1_pins = 0;
    logic [7:0] port2_output_latch = 0, reg_rdata, xram_high_addr;
    logic [1:0] kind = 0;
    logic       fetch_req, xram_rd_req, xram_wr_req, internal_low_rc_clk_pin;
    logic       mem_ready, cpu_clk_en, cpu_run, periph_clk_en, hosc_run;
    logic       internal_low_rc_run, lxtal_drive, idle_mode, stop_mode;
    logic       serial_double_rate;
    logic [3:0] low_st;
    logic [7:0] m [256], k [256];
    logic [7:0] ra [7] = '{ADDR_WAIT, ADDR_CSEL, ADDR_PWR, ADDR_P1W,
                           ADDR_CCMD, 8'h00, 8'hA5};
    int         err_count = 0, check_count = 0, lat, c, i, r, p, cyc = 0;

    cpmc_ctrl i_dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .internal_low_rc_clk_pin, .osc_is_rc_pin, .p0_pins, .p1_pins,
        .irq_pending, .port2_output_latch, .fetch_req, .xram_rd_req,
        .xram_wr_req, .mem_ready, .xram_high_addr, .cpu_clk_en, .cpu_run,
        .periph_clk_en, .hosc_run, .internal_low_rc_run, .lxtal_drive, .idle_mode,
        .stop_mode, .serial_double_rate);
    cpmc_cpu_model i_cpu (.clock, .kind, .go, .mem_ready, .fetch_req,
        .xram_rd_req, .xram_wr_req, .internal_low_rc_clk_pin, .lat);

    assign low_st = {stop_mode, internal_low_rc_run, lxtal_drive, serial_double_rate};

    initial forever #50 clock = ~clock;

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            err_count++;
            results();
        end
    end

    task results;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task at(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // the model keeps only stored bits; command register never reads back
    task wr(input logic [7:0] a, d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        if (a != ADDR_CCMD) m[a] = d & k[a];
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    task rc(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1 chk("rdata", m[a], reg_rdata);
    endtask
    task mem(input logic [1:0] t, input int e);
        @(posedge clock);
        kind <= t;
        go   <= 1'h1;
        @(posedge clock);
        go <= 1'h0;
        at(14);
        chk("latency", e, lat);
    endtask
    task cen(input int e);
        at(3);
        c = 0;
        repeat (256) begin
            at(1);
            c += cpu_clk_en === 1'h1;
        end
        chk("cpu_ticks", e, c);
    endtask
    task warm(input int lo, hi);
        c = 0;
        while (cpu_run !== 1'h1 && c < 3000) begin
            at(1);
            c++;
        end
        chk("warm_ok", 1, c >= lo && c <= hi);
    endtask

    initial begin
        k = '{default: 8'h00};
        m = '{default: 8'h00};
        k[ADDR_PWR] = 8'h9F;
        k[ADDR_WAIT] = 8'h7F;
        k[ADDR_CSEL] = 8'h87;
        k[ADDR_P1W] = 8'hFF;
        m[ADDR_PWR] = 8'h08;
        m[ADDR_WAIT] = 8'h71;
        m[ADDR_CSEL] = 8'h87;
        r = $urandom(32'h6DB8);
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        warm(2080, 2104);
        foreach (ra[j]) rc(ra[j]);
        foreach (ra[j]) begin
            r = $urandom;
            wr(ra[j], r[7:0] & 8'hFC);
            rc(ra[j]);
        end
        p = 7;
        for (i = 0; i < 8; i++) begin
            wr(ADDR_CSEL, {5'h10, i[2:0]});
            wr(ADDR_CCMD, 8'h96);
            cen(256 >> (7 - p));
            wr(ADDR_CCMD, CMD_KEY);
            cen(256 >> (7 - i));
            p = i;
        end
        wr(ADDR_CSEL, 8'h07);
        at(2);
        chk("low_src", 2'h2, {lxtal_drive, internal_low_rc_run});
        wr(ADDR_CSEL, 8'h87);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_WAIT, {1'h0, i[2:0], i[0], ~i[2:0]});
            mem(2'h0, 2 + i);
            mem(2'h1, 9 - i);
            mem(2'h2, 2 + i[0]);
        end
        r = $urandom;
        wr(ADDR_PWR, 8'h00);
        port2_output_latch <= r[15:8];
        at(3);
        chk("high_addr", r[15:8], xram_high_addr);
        wr(ADDR_PWR, 8'h08);
        at(3);
        chk("high_addr", 8'h00, xram_high_addr);
        wr(ADDR_PWR, 8'h09);
        at(3);
        chk("idle", 1'h1, idle_mode);
        @(posedge clock);
        irq_pending <= 1'h1;
        @(posedge clock);
        irq_pending <= 1'h0;
        at(3);
        chk("idle", 1'h0, idle_mode);
        m[ADDR_PWR] = 8'h08;
        rc(ADDR_PWR);
        wr(ADDR_P1W, 8'h04);
        wr(ADDR_PWR, 8'h18);
        wr(ADDR_PWR, 8'h1A);
        at(3);
        chk("stop", 4'hC, low_st);
        @(posedge clock);
        p1_pins <= 8'h08;
        at(8);
        chk("stop", 1'h1, stop_mode);
        @(posedge clock);
        p1_pins <= 8'h0C;
        warm(96, 124);
        m[ADDR_PWR] = 8'h18;
        rc(ADDR_PWR);
        // second stop: low clock dropped, crystal-type main oscillator
        wr(ADDR_PWR, 8'h88);
        osc_is_rc_pin <= 1'h0;
        wr(ADDR_PWR, 8'h8A);
        at(3);
        chk("stop", 4'h9, low_st);
        @(posedge clock);
        irq_pending <= 1'h1;
        @(posedge clock);
        irq_pending <= 1'h0;
        at(4);
        chk("stop", 1'h1, stop_mode);
        @(posedge clock);
        p0_pins <= 8'h01;
        warm(2080, 2104);
        m[ADDR_PWR] = 8'h88;
        rc(ADDR_PWR);
        results();
    end
endmodule
`default_nettype wire
